// File: rtl/xbn_ctrl.sv
// Expansion bus controller, normal mode access engine
`timescale 1ns/10ps
`default_nettype none
`include "xbn_defines.svh"

module xbn_ctrl
	import xbn_pkg::*;
#(
	parameter int NUM_CS = `XBN_NUM_CS
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	input  wire xbn_req_t              req,
	output logic                       req_ready,
	output xbn_rsp_t                   rsp,
	input  wire xbn_cs_cfg_t [3:0]     cs_cfg,
	input  wire logic [2:0]            clk_div,
	input  wire logic                  clk_out_en,
	input  wire logic                  mask_timing_select,
	input  wire logic                  nand_sel,
	input  wire logic                  re_active_high,
	input  wire logic                  we_active_high,
	input  wire logic                  rdy_in,
	output logic                       exp_clk_out,
	output logic [3:0]                 ext_chip_selects,
	output logic                       ext_read_strobe,
	output logic                       ext_write_strobe,
	output logic [23:0]                ext_addr,
	output logic [15:0]                ext_data_out,
	output logic                       ext_data_oe,
	input  wire logic [15:0]           ext_data_in,
	output logic [1:0]                 ext_byte_mask,
	output logic                       ext_byte_mask_oe,
	output xbn_mode_t [3:0]            cs_mode
);

	xbn_state_all_t s_reg;
	xbn_state_all_t s_next;

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------

	// Mode of one select from its two mode bits; the NAND select pin is separate
	function automatic xbn_mode_t mode_of(input xbn_cs_cfg_t c);
		if (c.latch_mode_bit && c.strobe_mode_bit) begin
			return XBN_MODE_NAND;
		end else if (c.latch_mode_bit) begin
			return XBN_MODE_LATCH;
		end else if (c.strobe_mode_bit) begin
			return XBN_MODE_STROBE;
		end
		return XBN_MODE_NORMAL;
	endfunction

	// Segment hit: one 16M window per select, upper bits zero
	function automatic logic seg_hit(input logic [31:0] a, input logic nsel);
		logic ok;
		ok = (a[31:`XBN_SEG_LSB + 2] == '0);
		if (nsel && (a[`XBN_ADDR_W - 1:`XBN_NAND_ADDR_W] != '0)) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	// Report the mode of every select
	genvar g;
	generate
		for (g = 0; g < NUM_CS; g++) begin : g_mode
			assign cs_mode[g] = mode_of(cs_cfg[g]);
		end
	endgenerate

	// ----------------------------------------
	// Next state
	// ----------------------------------------

	// One clock divider, access engine and ready catcher in one process
	always_comb begin
		xbn_cs_cfg_t c;
		logic [2:0]  dv;
		logic        tick;
		logic        rdy_edge;
		logic [7:0]  rd_word;
		s_next   = s_reg;
		c        = cs_cfg[s_reg.cs_idx];
		dv       = clk_div;
		tick     = 1'b0;
		rdy_edge = 1'b0;
		rd_word  = ext_data_in[7:0];
		s_next.rsp.done  = 1'b0;
		s_next.rsp.error = 1'b0;
		// Out-of-range divisors clamp so the clock never stops
		if (dv < `XBN_DIV_MIN) begin
			dv = `XBN_DIV_MIN;
		end
		// Divide the system clock; tick marks each expansion period
		tick = (s_reg.div_cnt >= dv - 3'h1);
		if (tick) begin
			s_next.div_cnt = 3'h0;
		end else begin
			s_next.div_cnt = s_reg.div_cnt + 3'h1;
		end
		s_next.exp_clk = (s_next.div_cnt < {1'b0, dv[2:1]}) ? 1'b0 : 1'b1;
		// Ready synchroniser, then an edge detect on the settled stages
		s_next.rdy_s1 = rdy_in;
		s_next.rdy_s2 = s_reg.rdy_s1;
		s_next.rdy_s3 = s_reg.rdy_s2;
		rdy_edge = c.rdy_rise ? (s_reg.rdy_s2 && !s_reg.rdy_s3)
			: (!s_reg.rdy_s2 && s_reg.rdy_s3);
		case (s_reg.st)
			XBN_ST_IDLE: begin
				s_next.cs_on   = 1'b0;
				s_next.strb_on = 1'b0;
				s_next.drive   = 1'b0;
				if (req.valid) begin
					if (!seg_hit(req.addr, nand_sel)) begin
						s_next.rsp.done  = 1'b1;
						s_next.rsp.error = 1'b1;
					end else begin
						s_next.cs_idx   = req.addr[`XBN_SEG_LSB + 1:`XBN_SEG_LSB];
						s_next.addr     = req.addr[`XBN_ADDR_W - 1:0];
						s_next.write    = req.write;
						s_next.wdata    = req.wdata;
						s_next.mask     = req.byte_mask;
						s_next.drive    = req.write;
						s_next.rdy_seen = 1'b0;
						s_next.cnt      = 8'h0;
						s_next.st       = XBN_ST_SETUP;
					end
				end
			end
			XBN_ST_SETUP: begin
				// Count expansion periods from a valid address
				if (tick) begin
					if (s_reg.cnt >= {4'h0, c.setup_cnt}) begin
						s_next.cs_on   = 1'b1;
						s_next.strb_on = 1'b1;
						s_next.cnt     = 8'h0;
						s_next.st      = XBN_ST_STRB;
					end else begin
						s_next.cnt = s_reg.cnt + 8'h1;
					end
				end
			end
			XBN_ST_STRB: begin
				if (tick) begin
					s_next.cnt = s_reg.cnt + 8'h1;
				end
				if (c.rdy_en && rdy_edge) begin
					s_next.rdy_seen = 1'b1;
				end
				// Ready ends it early; otherwise the width count does
				if ((c.rdy_en && rdy_edge) || (tick && s_reg.cnt >= c.width_cnt)) begin
					s_next.cs_on   = 1'b0;
					s_next.strb_on = 1'b0;
					s_next.cnt     = 8'h0;
					s_next.st      = XBN_ST_HOLD;
					if (!s_reg.write) begin
						if (c.bus_size == `XBN_BUS16) begin
							s_next.rsp.rdata = ext_data_in;
						end else begin
							s_next.rsp.rdata = {8'h0, rd_word};
						end
					end
					s_next.rsp.error = c.rdy_en && !(rdy_edge || s_reg.rdy_seen);
					s_next.rsp.done  = 1'b1;
				end
			end
			XBN_ST_HOLD: begin
				// Write data and address held until the hold count runs out
				if (tick) begin
					if (s_reg.cnt >= {4'h0, c.hold_cnt}) begin
						s_next.drive = 1'b0;
						s_next.st    = XBN_ST_IDLE;
					end else begin
						s_next.cnt = s_reg.cnt + 8'h1;
					end
				end
			end
			default: begin
				s_next.st = XBN_ST_IDLE;
			end
		endcase
		if (s_reg.write) begin
			s_next.rsp.rdata = s_reg.rsp.rdata;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------

	// Synchronous reset to a quiet bus
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			// Ready stages start at the idle pin level, so no false edge follows reset
			s_reg        <= '0;
			s_reg.rdy_s1 <= 1'b1;
			s_reg.rdy_s2 <= 1'b1;
			s_reg.rdy_s3 <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------

	// Handshake is combinational; pins come from flip-flops
	assign req_ready   = (s_reg.st == XBN_ST_IDLE);
	assign rsp         = s_reg.rsp;
	assign exp_clk_out = clk_out_en & s_reg.exp_clk;
	assign ext_addr    = s_reg.addr;
	assign ext_data_out = s_reg.wdata;
	assign ext_data_oe  = s_reg.drive;

	// Level per select; idle selects sit at their inactive level
	generate
		for (g = 0; g < NUM_CS; g++) begin : g_cs
			assign ext_chip_selects[g] = ~cs_cfg[g].cs_active_high ^
				(s_reg.cs_on && s_reg.cs_idx == 2'(g));
		end
	endgenerate

	// Only the strobe of this direction moves
	assign ext_read_strobe  = ~re_active_high ^ (s_reg.strb_on && !s_reg.write);
	assign ext_write_strobe = ~we_active_high ^ (s_reg.strb_on && s_reg.write);

	// Masks only while driving data, timed by select or write strobe
	assign ext_byte_mask    = s_reg.mask;
	assign ext_byte_mask_oe = s_reg.drive && (mask_timing_select ? s_reg.strb_on
		: s_reg.cs_on);

endmodule
`default_nettype wire

// File: rtl/xbn_defines.svh
// Constants for the expansion bus normal mode controller
//
// Behaviour
// - Each chip select picks normal, latch, strobe or NAND mode; normal by default.
// - Clock-output enable defaults to one; zero stops the expansion clock pin.
// - Normal mode when latch and strobe bits are both zero, on every select.
// - Expansion clock is the system clock divided by 3, 4, 5, 6 or 7.
// - Four chip selects, each with programmable level, active low by default.
// - Read strobe marks reads, write strobe marks writes; levels are programmable.
// - Two byte masks, high masks a byte, driven only while data is driven.
// - Mask timing follows chip select when zero, write strobe when one.
// - Ready is detected on a chosen edge and ends select and strobe.
// - 24-bit address per select; NAND selection limits NOR space to 256K.
// - Bus size 00 is 8 bits, 01 is 16 bits, others reserved.
// - Select and strobe assert a programmed number of clock cycles after address.
// - Reads leave data undriven; data captured when strobe or select ends.
// - Select ends on width count expiry, or earlier on detected ready.
// - Write data stays driven a programmed number of cycles after select ends.
// - No new transaction starts before the data-hold count expires.
// - Ready passes a two-stage synchroniser before it ends select or strobe.
// - Each chip select has its own ready-detection enable bit.
// - Ready enabled but not seen before select ends gives an error answer.
// - Only the strobe of the access direction toggles, never both.
// - Access outside the chip-select segments gets an error answer.
`ifndef XBN_DEFINES_SVH
`define XBN_DEFINES_SVH

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define XBN_NUM_CS       4
`define XBN_ADDR_W       24
`define XBN_NAND_ADDR_W  18
`define XBN_DIV_MIN      3'h3
`define XBN_DIV_MAX      3'h7
`define XBN_CLK_EN_RST   1'b1
`define XBN_BUS8         2'h0
`define XBN_BUS16        2'h1
`define XBN_SEG_LSB      24

`endif

// File: rtl/xbn_pkg.sv
// Types for the expansion bus normal mode controller
package xbn_pkg;

	typedef enum logic [1:0] {
		XBN_MODE_NORMAL = 2'h0,
		XBN_MODE_LATCH  = 2'h1,
		XBN_MODE_STROBE = 2'h2,
		XBN_MODE_NAND   = 2'h3
	} xbn_mode_t;

	// Gray coded along idle, setup, strobe, hold
	typedef enum logic [1:0] {
		XBN_ST_IDLE  = 2'h0,
		XBN_ST_SETUP = 2'h1,
		XBN_ST_STRB  = 2'h3,
		XBN_ST_HOLD  = 2'h2
	} xbn_state_t;

	// Per chip-select configuration
	typedef struct packed {
		logic       latch_mode_bit;
		logic       strobe_mode_bit;
		logic       cs_active_high;
		logic       rdy_en;
		logic       rdy_rise;
		logic [1:0] bus_size;
		logic [3:0] setup_cnt;
		logic [7:0] width_cnt;
		logic [3:0] hold_cnt;
	} xbn_cs_cfg_t;

	// Request from the AHB side
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [15:0] wdata;
		logic [1:0]  byte_mask;
	} xbn_req_t;

	// Answer to the AHB side
	typedef struct packed {
		logic        done;
		logic        error;
		logic [15:0] rdata;
	} xbn_rsp_t;

	// Whole state of the controller
	typedef struct packed {
		xbn_state_t  st;
		logic [2:0]  div_cnt;
		logic        exp_clk;
		logic [7:0]  cnt;
		logic [1:0]  cs_idx;
		logic        write;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic [1:0]  mask;
		logic        cs_on;
		logic        strb_on;
		logic        drive;
		logic        rdy_seen;
		logic        rdy_s1;
		logic        rdy_s2;
		logic        rdy_s3;
		xbn_rsp_t    rsp;
	} xbn_state_all_t;

endpackage

// File: dv/xbn_checker.sv
// Port-level assertions for the expansion bus controller
`timescale 1ns/10ps
`default_nettype none
module xbn_checker
	import xbn_pkg::*;
#(
	parameter int NUM_CS = 4
) (
	input wire logic              clk_sys,
	input wire logic              rstn,
	input wire xbn_req_t          req,
	input wire logic              req_ready,
	input wire xbn_rsp_t          rsp,
	input wire xbn_cs_cfg_t [3:0] cs_cfg,
	input wire logic              clk_out_en,
	input wire logic              mask_timing_select,
	input wire logic              nand_sel,
	input wire logic              re_active_high,
	input wire logic              we_active_high,
	input wire logic              exp_clk_out,
	input wire logic [3:0]        ext_chip_selects,
	input wire logic              ext_read_strobe,
	input wire logic              ext_write_strobe,
	input wire logic [23:0]       ext_addr,
	input wire logic              ext_data_oe,
	input wire logic              ext_byte_mask_oe
);
	logic [3:0] act;
	logic       re_act;
	logic       we_act;
	logic       any_cs;

	// Active view of each pin, polarity removed
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			act[i] = ext_chip_selects[i] == cs_cfg[i].cs_active_high;
		end
		re_act = ext_read_strobe == re_active_high;
		any_cs = |act;
		we_act = ext_write_strobe == we_active_high;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_strobe_excl: assert property (!(re_act && we_act))
		else $error("both strobes active");
	a_read_float: assert property (re_act |-> !ext_data_oe)
		else $error("data driven during read");
	a_mask_with_data: assert property (ext_byte_mask_oe |-> ext_data_oe)
		else $error("mask driven without data");
	// Masks copy the select or the write strobe, whichever the timing bit picks
	a_mask_follow: assert property (ext_data_oe |->
		ext_byte_mask_oe == (mask_timing_select ? we_act : any_cs))
		else $error("mask timing wrong");
	a_one_select: assert property ($onehot0(act))
		else $error("more than one select");
	a_addr_hold: assert property (any_cs && $past(any_cs) |-> $stable(ext_addr))
		else $error("address moved under select");
	a_addr_wr_hold: assert property (ext_data_oe && $past(ext_data_oe) |->
		$stable(ext_addr))
		else $error("address moved during write");
	a_range_error: assert property (req.valid && req_ready &&
		req.addr[31:26] != 6'h0 |-> ##[1:2] (rsp.done && rsp.error))
		else $error("no error outside segments");
	a_nand_error: assert property (req.valid && req_ready && nand_sel &&
		req.addr[23:18] != 6'h0 |-> ##[1:2] (rsp.done && rsp.error))
		else $error("no error above nand limit");
	a_hold_busy: assert property (ext_data_oe |-> !req_ready)
		else $error("ready during data hold");
	a_data_hold: assert property ($fell(we_act) |-> ext_data_oe)
		else $error("data dropped with write strobe");
	a_clk_gated: assert property (!clk_out_en && !$past(clk_out_en) |-> !exp_clk_out)
		else $error("clock out while disabled");
	a_reset_idle: assert property ($rose(rstn) |-> act == 4'h0 && !ext_data_oe)
		else $error("select active out of reset");
endmodule

bind xbn_ctrl xbn_checker #(.NUM_CS(NUM_CS)) chk_u (.clk_sys, .rstn, .req, .req_ready, .rsp,
	.cs_cfg, .clk_out_en, .nand_sel, .re_active_high, .we_active_high, .exp_clk_out,
	.ext_chip_selects, .ext_read_strobe, .ext_write_strobe, .ext_addr, .ext_data_oe,
	.ext_byte_mask_oe, .mask_timing_select);
`default_nettype wire

// File: dv/xbn_periph.sv
// Peripheral model: active-low selects and strobes only
`timescale 1ns/10ps
`default_nettype none
module xbn_periph #(
	parameter logic [15:0] RD_WORD = 16'hbeef
) (
	input wire logic        clk_sys,
	input wire logic [3:0]  cs_n,
	input wire logic        re_n,
	input wire logic        we_n,
	input wire logic [15:0] wd,
	input wire logic [1:0]  wm,
	input wire logic        mute,
	output logic [15:0]     rd,
	output logic            rdy,
	output logic [15:0]     wr_word,
	output logic [1:0]      wr_mask
);
	logic [3:0] busy = 4'h0;
	logic       we_q = 1'b1;

	// Latch data on the ending edge of the write strobe
	always @(posedge clk_sys) begin
		we_q <= we_n;
		if (!we_q && we_n) begin
			wr_word <= wd;
			wr_mask <= wm;
		end
		busy <= &cs_n ? 4'h0 : busy + {3'h0, busy != 4'hf};
	end

	// Low while busy, high when done; mute never finishes
	assign rdy = &cs_n || (!mute && busy >= 4'h3);
	// Released bus shows the inverse, not a stale value
	assign rd = !re_n ? RD_WORD : ~RD_WORD;
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the expansion bus controller
`timescale 1ns/10ps
`default_nettype none
module tb import xbn_pkg::*;;
	logic              clk_sys = 1'b0;
	logic              rstn = 1'b0;
	xbn_req_t          req = '0;
	xbn_rsp_t          rsp, got;
	xbn_cs_cfg_t [3:0] cs_cfg;
	logic [2:0]        clk_div = 3'h3;
	logic              clk_out_en = 1'b1, mask_timing_select = 1'b0, nand_sel = 1'b0;
	logic              mute = 1'b0, req_ready, rdy_in, exp_clk_out;
	logic              ext_read_strobe, ext_write_strobe, ext_data_oe, ext_byte_mask_oe;
	logic [3:0]        ext_chip_selects;
	logic [23:0]       ext_addr;
	logic [15:0]       ext_data_out, ext_data_in, wr_word;
	logic [1:0]        ext_byte_mask, wr_mask;
	xbn_mode_t [3:0]   cs_mode;
	int                err_count = 0, num_checks = 0;
	logic              re_active_high = 1'b0, we_active_high = 1'b0;
	int                hold_cyc = 0, rises = 0;

	always #25 clk_sys = ~clk_sys;

	xbn_ctrl dut_u (.clk_sys, .rstn, .req, .req_ready, .rsp, .cs_cfg, .clk_div, .clk_out_en,
		.mask_timing_select, .nand_sel, .re_active_high, .we_active_high, .rdy_in,
		.exp_clk_out, .ext_chip_selects, .ext_read_strobe, .ext_write_strobe, .ext_addr,
		.ext_data_out, .ext_data_oe, .ext_data_in, .ext_byte_mask, .ext_byte_mask_oe, .cs_mode);

	xbn_periph per_u (.clk_sys, .cs_n(ext_chip_selects), .re_n(ext_read_strobe),
		.we_n(ext_write_strobe), .wd(ext_data_out), .wm(ext_byte_mask), .mute,
		.rd(ext_data_in), .rdy(rdy_in), .wr_word, .wr_mask);

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Bounded step; a hang ends the run
	task automatic step(inout int n);
		n++;
		if (n > 4000) begin
			err_count++;
			report_and_stop();
		end
		@(posedge clk_sys);
		#1;
	endtask

	// Rising edges of the expansion clock over 30 sampled system clocks
	task automatic clk_rises(output int r);
		logic prev;
		r = 0;
		repeat (8) @(posedge clk_sys);
		prev = exp_clk_out;
		repeat (30) begin
			@(posedge clk_sys);
			if (exp_clk_out && !prev) r++;
			prev = exp_clk_out;
		end
	endtask

	// One transfer: request held for one clock, then wait for answer and idle
	task automatic acc(input logic w, input logic [31:0] a, input logic [15:0] d,
		input logic [1:0] m);
		int n;
		n = 0;
		@(posedge clk_sys);
		req <= '{1'b1, w, a, d, m};
		@(posedge clk_sys);
		req.valid <= 1'b0;
		#1;
		while (rsp.done !== 1'b1) step(n);
		got = rsp;
		hold_cyc = n;
		while (req_ready !== 1'b1) step(n);
		hold_cyc = n - hold_cyc;
	endtask

	initial begin
		for (int i = 0; i < 4; i++) cs_cfg[i] = '{0, 0, 0, 0, 1, 2'h1, 4'h1, 8'h6, 4'h2};
		cs_cfg[1].bus_size = 2'h0;
		cs_cfg[2].rdy_en = 1'b1;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		#1;
		chk("cs idle", ext_chip_selects, 4'hf);
		for (int i = 0; i < 4; i++) chk("mode", cs_mode[i], XBN_MODE_NORMAL);
		clk_rises(rises);
		chk("clk div3", rises, 10);
		acc(1, 32'h0012_3456, 16'ha5c3, 2'h1);
		chk("wr data", wr_word, 16'ha5c3);
		chk("wr mask", wr_mask, 2'h1);
		chk("wr err", got.error, 1'b0);
		chk("addr", ext_addr, 24'h12_3456);
		chk("oe off", ext_data_oe, 1'b0);
		chk("hold", hold_cyc, 9);
		mask_timing_select <= 1'b1;
		acc(1, 32'h0100_0010, 16'h3c5a, 2'h2);
		chk("wr mask we", wr_mask, 2'h2);
		acc(0, 32'h0000_0020, 16'h0, 2'h0);
		chk("rd16", got.rdata, 16'hbeef);
		acc(0, 32'h0100_0020, 16'h0, 2'h0);
		chk("rd8", got.rdata, 16'h00ef);
		acc(0, 32'h0200_0000, 16'h0, 2'h0);
		chk("rdy ok", got.error, 1'b0);
		mute <= 1'b1;
		acc(0, 32'h0200_0004, 16'h0, 2'h0);
		chk("rdy err", got.error, 1'b1);
		mute <= 1'b0;
		clk_out_en <= 1'b0;
		clk_rises(rises);
		chk("clk off", rises, 0);
		acc(1, 32'h0300_0000, 16'h1234, 2'h0);
		chk("async wr", wr_word, 16'h1234);
		clk_out_en <= 1'b1;
		acc(0, 32'h0400_0000, 16'h0, 2'h0);
		chk("seg err", got.error, 1'b1);
		nand_sel <= 1'b1;
		acc(0, 32'h0004_0000, 16'h0, 2'h0);
		chk("nand err", got.error, 1'b1);
		acc(0, 32'h0003_fff0, 16'h0, 2'h0);
		chk("nand ok", got.error, 1'b0);
		nand_sel <= 1'b0;
		// Other divisors, and a divisor below the range that clamps to three
		clk_div <= 3'h5;
		clk_rises(rises);
		chk("clk div5", rises, 6);
		clk_div <= 3'h6;
		clk_rises(rises);
		chk("clk div6", rises, 5);
		clk_div <= 3'h0;
		clk_rises(rises);
		chk("clk clamp", rises, 10);
		clk_div <= 3'h3;
		// Walk all four mode-bit pairs on the last select
		for (int m = 0; m < 4; m++) begin
			cs_cfg[3].latch_mode_bit <= m[0];
			cs_cfg[3].strobe_mode_bit <= m[1];
			@(posedge clk_sys);
			#1;
			chk("mode3", cs_mode[3], m);
		end
		cs_cfg[0].cs_active_high <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("cs pol", ext_chip_selects[0], 1'b0);
		// Active-high strobes sit low while idle
		re_active_high <= 1'b1;
		we_active_high <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk("re pol", ext_read_strobe, 1'b0);
		chk("we pol", ext_write_strobe, 1'b0);
		report_and_stop();
	end
endmodule
`default_nettype wire
